// ---- verilog/reset_source_supervisor.sv ----
// Reset source supervisor: merges supply monitors, external/software/logic/watchdog
// resets into one system reset. Assumes supply readings arrive as mV codes on clk.
// What this block does
// - Low-voltage trips selectable from 1.70 V upward in 250 mV steps.
// - Analog high-voltage interrupt when supply exceeds fixed 5.75 V.
// - Each low-voltage monitor can reset the device instead of interrupting.
// - Monitors stay silent until internal power-on reset is released.
// - In sleep, monitors sample only during short periodic windows.
// - Sleep-window monitor interrupt starts wakeup, presented after wakeup ends.
// - External reset taken from dedicated pin or configured general pin.
// - Device held in reset while external reset input is low.
// - External reset resets the device like power-on reset but keeps the watchdog enable and records its own cause bit.
// - External reset works during sleep and hibernate.
// - Software reset bit write, by processor or DMA, resets device.
// - Software reset acts like power-on reset but keeps the watchdog enable and records its own cause bit.
// - Disable bit makes software reset writes ineffective.
// - Logic reset counts only when routed to reset pin in reset mode.
// - Enabled watchdog resets device when not cleared before timeout.
// - Watchdog off after power-on reset until software enables it.
// - Watchdog enable is sticky; only power-on reset clears it.
`timescale 1ns/100ps
module reset_source_supervisor #(
    parameter int SAMPLE_PERIOD = reset_source_supervisor_pkg::SAMPLE_PERIOD_CYC
) (
    input  wire logic                                       clk,
    input  wire logic                                       rst,
    input  wire logic                                       external_reset_pin_n,
    input  wire logic                                       gpio_reset_pin_n,
    input  wire logic                                       gpio_reset_select,
    input  wire logic                                       logic_driven_reset,
    input  wire logic                                       logic_route_to_pin,
    input  wire logic                                       configurable_reset_pin_mode,
    input  wire logic                                       software_reset_write,
    input  wire logic                                       software_reset_value,
    input  wire logic                                       software_reset_disable,
    input  wire logic                                       watchdog_enable_write,
    input  wire logic                                       watchdog_clear,
    input  wire logic [reset_source_supervisor_pkg::WDT_CNT_W-1:0] watchdog_timeout,
    input  wire reset_source_supervisor_pkg::monitor_cfg_t  monitor_cfg,
    input  wire logic [reset_source_supervisor_pkg::MV_W-1:0] vddd_mv,
    input  wire logic [reset_source_supervisor_pkg::MV_W-1:0] vdda_mv,
    input  wire logic                                       sleep_mode,
    input  wire logic                                       hibernate_mode,
    output logic                                            system_reset,
    output logic                                            watchdog_enabled,
    output logic [reset_source_supervisor_pkg::SRC_N-1:0]   reset_cause,
    output reset_source_supervisor_pkg::monitor_irq_t       monitor_irq,
    output logic                                            monitor_sampling,
    output logic                                            wakeup_request,
    output logic                                            wakeup_busy
);

    typedef enum logic [1:0] {AWAKE, ASLEEP, WAKING} power_state_t;

    // Trip threshold in mV from a code
    function automatic logic [reset_source_supervisor_pkg::MV_W-1:0] trip_mv(
        input logic [reset_source_supervisor_pkg::TRIP_CODE_W-1:0] code);
        int v;
        v = reset_source_supervisor_pkg::TRIP_BASE_MV
            + int'(code) * reset_source_supervisor_pkg::TRIP_STEP_MV;
        return v[reset_source_supervisor_pkg::MV_W-1:0];
    endfunction

    localparam logic [reset_source_supervisor_pkg::MV_W-1:0] HIGH_TRIP =
        13'(reset_source_supervisor_pkg::HIGH_TRIP_MV);

    // Pin synchronisers: three stages, change counts when stages 2 and 3 agree
    logic [2:0] ext_sync;
    logic [2:0] gpio_sync;
    logic       ext_level_n;
    logic       gpio_level_n;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_sync  <= 3'h7;
            gpio_sync <= 3'h7;
        end else begin
            ext_sync  <= {ext_sync[1:0], external_reset_pin_n};
            gpio_sync <= {gpio_sync[1:0], gpio_reset_pin_n};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_level_n  <= 1'b1;
            gpio_level_n <= 1'b1;
        end else begin
            if (ext_sync[1] == ext_sync[2])
                ext_level_n <= ext_sync[2];
            if (gpio_sync[1] == gpio_sync[2])
                gpio_level_n <= gpio_sync[2];
        end
    end

    // Pin chosen as the external reset; no gating by sleep or hibernate
    logic ext_active;
    assign ext_active = gpio_reset_select ? ~gpio_level_n : ~ext_level_n;

    // Logic reset reaches the device only through the pin in reset mode
    logic logic_active;
    assign logic_active = logic_driven_reset & logic_route_to_pin
                          & configurable_reset_pin_mode;

    // Software reset: a write of one, unless disabled
    logic sw_fire;
    assign sw_fire = software_reset_write & software_reset_value
                     & ~software_reset_disable;

    // Monitor comparisons, enabled only after power-on reset release
    logic monitors_live;
    logic sample_now;
    logic digital_low;
    logic analog_low;
    logic analog_high;
    power_state_t state;

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            monitors_live <= 1'b0;
        else
            monitors_live <= 1'b1;
    end

    assign digital_low = vddd_mv < trip_mv(monitor_cfg.digital_trip);
    assign analog_low  = vdda_mv < trip_mv(monitor_cfg.analog_trip);
    assign analog_high = vdda_mv > HIGH_TRIP;

    // Sleep sampling windows
    logic [reset_source_supervisor_pkg::SAMPLE_CNT_W-1:0] sample_cnt;
    localparam logic [reset_source_supervisor_pkg::SAMPLE_CNT_W-1:0] WINDOW_LEN =
        16'(reset_source_supervisor_pkg::SAMPLE_WINDOW_CYC);

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            sample_cnt <= 16'h0000;
        else if (state != ASLEEP)
            sample_cnt <= 16'h0000;
        else if (sample_cnt >= 16'(SAMPLE_PERIOD - 1))
            sample_cnt <= 16'h0000;
        else
            sample_cnt <= sample_cnt + 16'h0001;
    end

    assign monitor_sampling = monitors_live & ((state != ASLEEP) | (sample_cnt < WINDOW_LEN));
    assign sample_now = monitor_sampling & ~system_reset;

    logic dlv_trip;
    logic alv_trip;
    logic ahv_trip;
    logic lv_reset;
    assign dlv_trip = sample_now & digital_low;
    assign alv_trip = sample_now & analog_low;
    assign ahv_trip = sample_now & analog_high;
    assign lv_reset = (dlv_trip & monitor_cfg.digital_lv_reset_mode)
                      | (alv_trip & monitor_cfg.analog_lv_reset_mode);

    // Pending interrupts, held until wakeup completes, then presented
    reset_source_supervisor_pkg::monitor_irq_t pending;
    logic any_irq_event;
    assign any_irq_event = (dlv_trip & ~monitor_cfg.digital_lv_reset_mode)
                           | (alv_trip & ~monitor_cfg.analog_lv_reset_mode) | ahv_trip;

    logic [reset_source_supervisor_pkg::WAKE_CNT_W-1:0] wake_cnt;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= AWAKE;
            wake_cnt <= 4'h0;
        end else if (system_reset) begin
            state    <= AWAKE;
            wake_cnt <= 4'h0;
        end else begin
            unique case (state)
                AWAKE: if (sleep_mode) begin
                    state <= ASLEEP;
                end
                // A withdrawn sleep request must not strand the block asleep
                ASLEEP: if (any_irq_event) begin
                    state    <= WAKING;
                    wake_cnt <= 4'(reset_source_supervisor_pkg::WAKE_CYC - 1);
                end else if (~sleep_mode) begin
                    state <= AWAKE;
                end
                WAKING: if (wake_cnt == 4'h0) begin
                    state <= AWAKE;
                end else begin
                    wake_cnt <= wake_cnt - 4'h1;
                end
            endcase
        end
    end

    assign wakeup_request = (state == ASLEEP) & any_irq_event;
    assign wakeup_busy    = (state == WAKING);

    // Level-style interrupt: sticky while tripped, presented only when awake
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending <= '0;
        end else if (system_reset) begin
            pending <= '0;
        end else begin
            pending.digital_low_voltage_irq <= (dlv_trip & ~monitor_cfg.digital_lv_reset_mode)
                | (pending.digital_low_voltage_irq & ~(state == AWAKE & ~dlv_trip));
            pending.analog_low_voltage_irq  <= (alv_trip & ~monitor_cfg.analog_lv_reset_mode)
                | (pending.analog_low_voltage_irq & ~(state == AWAKE & ~alv_trip));
            pending.analog_high_voltage_irq <= ahv_trip
                | (pending.analog_high_voltage_irq & ~(state == AWAKE & ~ahv_trip));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            monitor_irq <= '0;
        else if (state == AWAKE)
            monitor_irq <= pending;
        else
            monitor_irq <= '0;
    end

    // Watchdog: enable sticky, cleared only by power-on reset
    logic [reset_source_supervisor_pkg::WDT_CNT_W-1:0] wdt_cnt;
    logic wdt_fire;

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            watchdog_enabled <= 1'b0;
        else if (watchdog_enable_write)
            watchdog_enabled <= 1'b1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            wdt_cnt <= '0;
        else if (system_reset | ~watchdog_enabled | watchdog_clear)
            wdt_cnt <= '0;
        else if (~wdt_fire)
            wdt_cnt <= wdt_cnt + 24'h000001;
    end

    assign wdt_fire = watchdog_enabled & (wdt_cnt >= watchdog_timeout);

    // Merge sources; reset is registered one cycle later, so a one-cycle event gives a one-cycle reset
    logic [reset_source_supervisor_pkg::SRC_N-1:0] cause_now;
    always_comb begin
        cause_now = '0;
        cause_now[reset_source_supervisor_pkg::SRC_EXT]   = ext_active;
        cause_now[reset_source_supervisor_pkg::SRC_SW]    = sw_fire;
        cause_now[reset_source_supervisor_pkg::SRC_LOGIC] = logic_active;
        cause_now[reset_source_supervisor_pkg::SRC_WDT]   = wdt_fire;
        cause_now[reset_source_supervisor_pkg::SRC_LV]    = lv_reset;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            system_reset <= 1'b1;
            reset_cause  <= 6'h01;
        end else begin
            system_reset <= |cause_now;
            if (|cause_now)
                reset_cause <= cause_now;
        end
    end

    // All checks run on clk and stay quiet while the power-on reset is held
    a_ext_holds: assert property (@(posedge clk) disable iff (rst)
        ext_active |=> system_reset)
        else $error("external reset low but system not in reset");

    a_ext_lowpower: assert property (@(posedge clk) disable iff (rst)
        (ext_active & (sleep_mode | hibernate_mode)) |=> system_reset)
        else $error("external reset ignored in a low-power mode");

    a_gpio_pick: assert property (@(posedge clk) disable iff (rst)
        (gpio_reset_select & ~gpio_level_n) |=> system_reset)
        else $error("general pin reset ignored while selected");

    a_logic_gate: assert property (@(posedge clk) disable iff (rst)
        (logic_driven_reset & ~configurable_reset_pin_mode & ~ext_active & ~sw_fire
         & ~wdt_fire & ~lv_reset) |=> ~system_reset)
        else $error("logic reset acted without reset pin mode");

    a_sw_disable: assert property (@(posedge clk) disable iff (rst)
        (software_reset_write & software_reset_disable & ~ext_active & ~logic_active
         & ~wdt_fire & ~lv_reset) |=> ~system_reset)
        else $error("disabled software reset still reset");

    a_sw_fires: assert property (@(posedge clk) disable iff (rst)
        (software_reset_write & software_reset_value & ~software_reset_disable)
        |=> system_reset && reset_cause[reset_source_supervisor_pkg::SRC_SW])
        else $error("software reset write did not reset");

    a_cause_latch: assert property (@(posedge clk) disable iff (rst)
        (|cause_now) |=> system_reset && reset_cause == $past(cause_now))
        else $error("active reset source not merged into system reset");

    a_lv_reset: assert property (@(posedge clk) disable iff (rst)
        (dlv_trip & monitor_cfg.digital_lv_reset_mode)
        |=> system_reset && reset_cause[reset_source_supervisor_pkg::SRC_LV])
        else $error("low-voltage trip in reset mode did not reset");

    a_por_quiet: assert property (@(posedge clk) disable iff (rst)
        ~monitors_live |-> ~monitor_sampling && ~lv_reset)
        else $error("monitor active before power-on reset release");

    a_wdt_sticky: assert property (@(posedge clk) disable iff (rst)
        watchdog_enabled |=> watchdog_enabled)
        else $error("watchdog enable cleared without power-on reset");

    a_wdt_idle: assert property (@(posedge clk) disable iff (rst)
        ~watchdog_enabled |=> wdt_cnt == '0)
        else $error("watchdog counting while disabled");

    a_wdt_timeout: assert property (@(posedge clk) disable iff (rst)
        (watchdog_enabled & wdt_cnt >= watchdog_timeout) |=> system_reset)
        else $error("watchdog timeout missed");

    a_high_trip: assert property (@(posedge clk) disable iff (rst)
        (sample_now & ~sleep_mode & state == AWAKE & vdda_mv > HIGH_TRIP) |=> ##1
        monitor_irq.analog_high_voltage_irq)
        else $error("high voltage interrupt missing");

    sequence s_sleep_trip;
        state == ASLEEP && any_irq_event;
    endsequence

    sequence s_wake_done;
        (state == WAKING && monitor_irq == '0)[*8] ##1 state == AWAKE;
    endsequence

    a_wake_first: assert property (@(posedge clk) disable iff (rst | system_reset)
        s_sleep_trip |=> s_wake_done)
        else $error("interrupt presented before wakeup completed");

    a_irq_held: assert property (@(posedge clk) disable iff (rst)
        (state != AWAKE) |=> monitor_irq == '0)
        else $error("interrupt presented while not awake");

    a_sleep_window: assert property (@(posedge clk) disable iff (rst)
        (state == ASLEEP && sample_cnt >= WINDOW_LEN) |-> ~monitor_sampling && ~wakeup_request)
        else $error("monitor sampling outside sleep window");

endmodule // reset_source_supervisor

// ---- verilog/reset_source_supervisor_pkg.sv ----
// Constants and carrier types for the reset source supervisor.
// Assumes a 20 MHz system clock and thermometer-free digital comparator results.
package reset_source_supervisor_pkg;
    // Clock
    localparam int CLK_HZ               = 20_000_000;
    // Low-voltage trip code: trip = 1700 mV + code * 250 mV
    localparam int TRIP_BASE_MV         = 1700;
    localparam int TRIP_STEP_MV         = 250;
    localparam int TRIP_CODE_W          = 4;
    localparam logic [TRIP_CODE_W-1:0] TRIP_CODE_RESET = 4'h0;
    localparam int HIGH_TRIP_MV         = 5750;
    // Supply measurement in millivolts
    localparam int MV_W                 = 13;
    // Sleep sampling: window open time and period, in microseconds
    localparam int SAMPLE_WINDOW_US     = 5;
    localparam int SAMPLE_PERIOD_US     = 1000;
    localparam int SAMPLE_WINDOW_CYC    = (SAMPLE_WINDOW_US * (CLK_HZ / 1_000_000) > 0) ?
                                          SAMPLE_WINDOW_US * (CLK_HZ / 1_000_000) : 1;
    localparam int SAMPLE_PERIOD_CYC    = SAMPLE_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam int SAMPLE_CNT_W         = 16;
    // Watchdog
    localparam int WDT_CNT_W            = 24;
    // Wakeup sequence length in cycles
    localparam int WAKE_CYC             = 8;
    localparam int WAKE_CNT_W           = 4;
    // Reset source bit positions in the cause word
    localparam int SRC_POR              = 0;
    localparam int SRC_EXT              = 1;
    localparam int SRC_SW               = 2;
    localparam int SRC_LOGIC            = 3;
    localparam int SRC_WDT              = 4;
    localparam int SRC_LV               = 5;
    localparam int SRC_N                = 6;

    typedef struct packed {
        logic [TRIP_CODE_W-1:0] digital_trip;
        logic [TRIP_CODE_W-1:0] analog_trip;
        logic                   digital_lv_reset_mode;
        logic                   analog_lv_reset_mode;
    } monitor_cfg_t;

    typedef struct packed {
        logic analog_low_voltage_irq;
        logic digital_low_voltage_irq;
        logic analog_high_voltage_irq;
    } monitor_irq_t;
endpackage

// ---- tb/supply_pin_model.sv ----
// Far-side model: the two active-low reset pins with pull-ups and the supply readings.
// Assumes the bench changes its requests just after a rising clock edge.
`timescale 1ns/100ps
module supply_pin_model (
    input  wire logic                                         hold_dedicated,
    input  wire logic                                         hold_gpio,
    input  wire logic [reset_source_supervisor_pkg::MV_W-1:0] vddd_level,
    input  wire logic [reset_source_supervisor_pkg::MV_W-1:0] vdda_level,
    output logic                                              external_reset_pin_n,
    output logic                                              gpio_reset_pin_n,
    output logic [reset_source_supervisor_pkg::MV_W-1:0]      vddd_mv,
    output logic [reset_source_supervisor_pkg::MV_W-1:0]      vdda_mv
);
    // A released pin is pulled up, so it never shows a stale low
    assign external_reset_pin_n = hold_dedicated ? 1'b0 : 1'b1;
    assign gpio_reset_pin_n     = hold_gpio ? 1'b0 : 1'b1;
    assign vddd_mv              = vddd_level;
    assign vdda_mv              = vdda_level;
endmodule // supply_pin_model

// ---- tb/reset_source_supervisor_tb_top.sv ----
// Self-checking bench for the reset source supervisor.
// Assumes a 20 MHz clock; inputs change 1 ns after each rising edge.
`timescale 1ns/100ps
module reset_source_supervisor_tb_top;
    logic        clk, rst, gpio_reset_select, logic_driven_reset, logic_route_to_pin;
    logic        configurable_reset_pin_mode, software_reset_write, software_reset_value;
    logic        software_reset_disable, watchdog_enable_write, watchdog_clear;
    logic        sleep_mode, hibernate_mode, hold_dedicated, hold_gpio;
    logic        external_reset_pin_n, gpio_reset_pin_n, system_reset, watchdog_enabled;
    logic        monitor_sampling, wakeup_request, wakeup_busy;
    logic [23:0] watchdog_timeout;
    logic [12:0] vddd_level, vdda_level, vddd_mv, vdda_mv;
    logic [5:0]  reset_cause;
    int          error_cnt, cmp_count, trip;
    reset_source_supervisor_pkg::monitor_cfg_t monitor_cfg;
    reset_source_supervisor_pkg::monitor_irq_t monitor_irq;

    // Short sleep period keeps the run small; window stays inside it
    reset_source_supervisor #(.SAMPLE_PERIOD(200)) reset_source_supervisor_inst (
        .clk, .rst, .external_reset_pin_n, .gpio_reset_pin_n, .gpio_reset_select,
        .logic_driven_reset, .logic_route_to_pin, .configurable_reset_pin_mode,
        .software_reset_write, .software_reset_value, .software_reset_disable,
        .watchdog_enable_write, .watchdog_clear, .watchdog_timeout, .monitor_cfg,
        .vddd_mv, .vdda_mv, .sleep_mode, .hibernate_mode, .system_reset, .watchdog_enabled,
        .reset_cause, .monitor_irq, .monitor_sampling, .wakeup_request, .wakeup_busy);

    supply_pin_model supply_pin_model_inst (
        .hold_dedicated, .hold_gpio, .vddd_level, .vdda_level,
        .external_reset_pin_n, .gpio_reset_pin_n, .vddd_mv, .vdda_mv);

    always #25 clk = ~clk;

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Watches system_reset for n cycles against one level
    task automatic hold_check(input int n, input logic exp);
        for (int i = 0; i < n; i++) begin
            tick(1);
            check("system_reset", {7'h00, system_reset}, {7'h00, exp});
        end
    endtask

    task automatic wait_until(input int sel, input int limit);
        int   n;
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit && n < limit) begin
            tick(1);
            n++;
            case (sel)
                0: hit = (system_reset === 1'b1);
                1: hit = (system_reset === 1'b0);
                2: hit = (wakeup_request === 1'b1);
                3: hit = (wakeup_busy === 1'b0);
                4: hit = (monitor_sampling === 1'b1);
                default: hit = (monitor_sampling === 1'b0);
            endcase
        end
        cmp_count++;
        if (!hit) begin
            error_cnt++;
            $display("unexpected timeout on wait %0d expected 1 seen 0", sel);
            end_of_test();
        end
    endtask

    task automatic sw_pulse();
        software_reset_write = 1'b1;
        software_reset_value = 1'b1;
        tick(1);
        software_reset_write = 1'b0;
    endtask

    initial begin
        {clk, gpio_reset_select, logic_driven_reset, logic_route_to_pin} = 4'h0;
        {configurable_reset_pin_mode, software_reset_write, software_reset_value} = 3'h0;
        {software_reset_disable, watchdog_enable_write, watchdog_clear} = 3'h0;
        {sleep_mode, hibernate_mode, hold_dedicated, hold_gpio} = 4'h0;
        error_cnt = 0;
        cmp_count = 0;
        rst = 1'b1;
        watchdog_timeout = 24'h000028;
        monitor_cfg = '0;
        vddd_level = 13'h05DC;
        vdda_level = 13'h0CE4;
        repeat (6) @(posedge clk);
        #1;
        check("irq in por", {5'h00, monitor_irq}, 8'h00);
        check("wdt in por", {7'h00, watchdog_enabled}, 8'h00);
        rst = 1'b0;
        tick(2);
        vddd_level = 13'h0CE4;
        tick(6);
        check("cause after por", {2'h0, reset_cause}, 8'h01);
        // Trip codes 0, 5, 10 and 15, each just below and just above its level
        for (int code = 0; code < 16; code += 5) begin
            monitor_cfg.digital_trip = code[3:0];
            monitor_cfg.analog_trip = code[3:0];
            trip = 1700 + code * 250;
            vddd_level = 13'(trip - 10);
            vdda_level = 13'(trip - 10);
            tick(6);
            check("lv irq low", {5'h00, monitor_irq}, 8'h06);
            vddd_level = 13'(trip + 10);
            vdda_level = 13'(trip + 10);
            tick(6);
            check("lv irq high", {5'h00, monitor_irq}, 8'h00);
        end
        monitor_cfg = '0;
        vdda_level = 13'h1680;
        tick(6);
        check("hv irq", {5'h00, monitor_irq}, 8'h01);
        vdda_level = 13'h1670;
        tick(6);
        check("hv irq off", {5'h00, monitor_irq}, 8'h00);
        monitor_cfg.digital_lv_reset_mode = 1'b1;
        vddd_level = 13'h0500;
        wait_until(0, 10);
        check("lv cause", {2'h0, reset_cause}, 8'h20);
        check("lv no irq", {5'h00, monitor_irq}, 8'h00);
        vddd_level = 13'h0CE4;
        wait_until(1, 10);
        sw_pulse();
        check("sw reset", {7'h00, system_reset}, 8'h01);
        check("sw cause", {2'h0, reset_cause}, 8'h04);
        wait_until(1, 4);
        software_reset_disable = 1'b1;
        sw_pulse();
        hold_check(6, 1'b0);
        software_reset_disable = 1'b0;
        logic_driven_reset = 1'b1;
        configurable_reset_pin_mode = 1'b1;
        hold_check(6, 1'b0);
        {logic_route_to_pin, configurable_reset_pin_mode} = 2'b10;
        hold_check(6, 1'b0);
        configurable_reset_pin_mode = 1'b1;
        wait_until(0, 4);
        check("logic cause", {2'h0, reset_cause}, 8'h08);
        logic_driven_reset = 1'b0;
        wait_until(1, 4);
        hold_dedicated = 1'b1;
        wait_until(0, 8);
        hold_check(20, 1'b1);
        check("ext cause", {2'h0, reset_cause}, 8'h02);
        hold_dedicated = 1'b0;
        wait_until(1, 8);
        gpio_reset_select = 1'b1;
        hold_gpio = 1'b1;
        wait_until(0, 8);
        hold_gpio = 1'b0;
        wait_until(1, 8);
        gpio_reset_select = 1'b0;
        {sleep_mode, hibernate_mode} = 2'b11;
        tick(3);
        hold_dedicated = 1'b1;
        wait_until(0, 8);
        hold_dedicated = 1'b0;
        wait_until(1, 8);
        {sleep_mode, hibernate_mode} = 2'b10;
        wait_until(4, 400);
        wait_until(5, 400);
        vdda_level = 13'h05DC;
        wait_until(2, 400);
        check("irq before wake", {5'h00, monitor_irq}, 8'h00);
        wait_until(3, 20);
        tick(1);
        check("irq after wake", {5'h00, monitor_irq}, 8'h04);
        sleep_mode = 1'b0;
        vdda_level = 13'h0CE4;
        tick(6);
        watchdog_enable_write = 1'b1;
        tick(1);
        watchdog_enable_write = 1'b0;
        tick(2);
        check("wdt on", {7'h00, watchdog_enabled}, 8'h01);
        // Firmware clears well inside the 40-cycle timeout
        for (int i = 0; i < 5; i++) begin
            watchdog_clear = 1'b1;
            tick(1);
            watchdog_clear = 1'b0;
            hold_check(25, 1'b0);
        end
        wait_until(0, 60);
        check("wdt cause", {2'h0, reset_cause}, 8'h10);
        wait_until(1, 8);
        check("wdt sticky", {7'h00, watchdog_enabled}, 8'h01);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(2);
        check("wdt after por", {7'h00, watchdog_enabled}, 8'h00);
        end_of_test();
    end
endmodule // reset_source_supervisor_tb_top
